/* rtl/ssr_pkg.sv */
// Package for the status and interrupt-cause register group.
// Assumes an APB slave with 32-bit data and byte addresses.
package ssr_pkg;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TARGET_ID = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h14;
    localparam logic [7:0] ADDR_SEL_TIMEOUT = 8'h14;
    localparam logic [7:0] ADDR_STEP = 8'h18;
    localparam logic [7:0] ADDR_CONTROL = 8'h20;
    localparam logic [7:0] ADDR_EVENT = 8'h24;
    localparam logic [7:0] IDX_STATUS = 8'h04;
    localparam logic [7:0] IDX_IRQ_CAUSE = 8'h05;
    localparam logic [7:0] IDX_STEP = 8'h06;
    localparam int CTL_EXT_GROUPS = 0;
    localparam int CTL_PHASE_LATCH = 1;
    localparam int CTL_RESET_REPORT = 2;
    localparam int CTL_INITIATOR = 3;
    localparam int ST_GROUP_KNOWN = 3;
    localparam int IC_BUS_RESET = 7;
    localparam int IC_BAD_OPCODE = 6;
    localparam int IC_LINK_DROPPED = 5;
    localparam int IC_SERVICE_REQ = 4;
    localparam int IC_DONE_OK = 3;
    localparam int IC_RECALLED = 2;
    localparam int IC_CHOSEN_ATN = 1;
    localparam int IC_CHOSEN = 0;
    localparam int STEP_SYNC_OFFSET = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] IRQ_CAUSE_RESET = 8'h00;
    localparam logic [2:0] STEP_RESET = 3'h0;
    localparam logic [3:0] CONTROL_RESET = 4'h0;
    localparam logic [7:0] TIMEOUT_RESET = 8'h00;
    localparam int PRESCALE_UNIT = 8192;
    localparam logic [2:0] RATIO_RESET = 3'h5;
    localparam logic [2:0] GROUP_TWO = 3'h2;
    localparam logic [2:0] GROUP_THREE = 3'h3;
    localparam logic [2:0] GROUP_FOUR = 3'h4;
    localparam logic [2:0] GROUP_SIX = 3'h6;
    localparam logic [2:0] GROUP_SEVEN = 3'h7;
    localparam logic [3:0] LEN_SIX = 4'h6;
    localparam logic [3:0] LEN_TEN = 4'ha;
    localparam logic [3:0] LEN_TWELVE = 4'hc;

    typedef struct packed {
        logic bus_reset_seen;
        logic bad_opcode;
        logic dropped;
        logic service_req;
        logic done_ok;
        logic recalled;
        logic chosen;
        logic chosen_atn;
    } ssr_event_type;

    typedef struct packed {
        logic known;
        logic vendor;
        logic reserved;
        logic [3:0] length;
    } ssr_cdb_class_type;
endpackage

/* rtl/ssr_regs.sv */
// Status, interrupt-cause, target-ID, timeout and sequence-step registers.
// Assumes an APB master on pclk; bus signals arrive from pins and are synchronised.
`timescale 1ns/100ps
`default_nettype none
module ssr_regs #(
    parameter int UNIT_CYCLES = ssr_pkg::PRESCALE_UNIT
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer side
    input wire logic soft_reset,
    input wire logic [2:0] clock_ratio,
    input wire logic cdb_valid,
    input wire logic [2:0] cdb_group,
    input wire logic cmd_end,
    input wire logic step_valid,
    input wire logic [2:0] step_code,
    input wire logic sync_offset_full,
    input wire logic sel_start,
    input wire logic sel_done,
    input wire ssr_pkg::ssr_event_type events,
    // Bus pins
    input wire logic [2:0] bus_phase_pin,
    input wire logic bus_reset_pin,
    // Outputs
    output logic [2:0] target_id,
    output logic sel_timeout,
    output ssr_pkg::ssr_cdb_class_type cdb_class
);
    logic [2:0] phase_s1_q, phase_s2_q;
    logic rst_s1_q, rst_s2_q, rst_s3_q;
    logic [7:0] status_q, status_d;
    logic [7:0] cause_q, cause_d;
    logic [2:0] step_q, step_d;
    logic [3:0] ctl_q, ctl_d;
    logic [7:0] tmo_q, tmo_d;
    logic [2:0] phase_hold_q, phase_hold_d;
    logic latched_q, latched_d;
    logic [31:0] prdata_d;
    logic pslverr_d;
    logic [2:0] tid_q, tid_d;
    logic timing_q, timing_d;
    logic [15:0] pre_q, pre_d;
    logic [7:0] wraps_q, wraps_d;
    logic sel_timeout_d;
    ssr_pkg::ssr_cdb_class_type cls, cdb_class_d;
    logic rd, wr, cause_read, bus_reset_rise;
    logic [15:0] pre_limit;
    ssr_pkg::ssr_event_type ev;

    // Pins into the clock domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_s1_q <= 3'h0;
            phase_s2_q <= 3'h0;
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
            rst_s3_q <= 1'b0;
        end else begin
            phase_s1_q <= bus_phase_pin;
            phase_s2_q <= phase_s1_q;
            rst_s1_q <= bus_reset_pin;
            rst_s2_q <= rst_s1_q;
            rst_s3_q <= rst_s2_q;
        end
    end

    assign rd = psel && penable && !pwrite;
    assign wr = psel && penable && pwrite;
    assign cause_read = rd && (paddr == ssr_pkg::ADDR_IRQ_CAUSE);
    assign bus_reset_rise = rst_s2_q && !rst_s3_q;
    assign pre_limit = 16'(UNIT_CYCLES * ((clock_ratio == 3'h0) ? 8 : int'(clock_ratio)) - 1);

    // Command group classification
    always_comb begin
        cls = '0;
        cls.length = ssr_pkg::LEN_SIX;
        case (cdb_group)
            ssr_pkg::GROUP_TWO: begin
                if (ctl_q[ssr_pkg::CTL_EXT_GROUPS]) begin
                    cls.known = 1'b1;
                    cls.length = ssr_pkg::LEN_TEN;
                end else begin
                    cls.reserved = 1'b1;
                end
            end
            ssr_pkg::GROUP_THREE, ssr_pkg::GROUP_FOUR: begin
                cls.reserved = 1'b1;
            end
            ssr_pkg::GROUP_SIX: begin
                cls.vendor = 1'b1;
            end
            ssr_pkg::GROUP_SEVEN: begin
                cls.vendor = 1'b1;
                cls.length = ssr_pkg::LEN_TEN;
            end
            3'h1: begin
                cls.known = 1'b1;
                cls.length = ssr_pkg::LEN_TEN;
            end
            3'h5: begin
                cls.known = 1'b1;
                cls.length = ssr_pkg::LEN_TWELVE;
            end
            default: begin
                cls.known = 1'b1;
            end
        endcase
    end

    // Register next values
    always_comb begin
        ev = events;
        ev.bus_reset_seen = bus_reset_rise && ctl_q[ssr_pkg::CTL_RESET_REPORT];
        status_d = status_q;
        cause_d = cause_q;
        step_d = step_q;
        ctl_d = ctl_q;
        tmo_d = tmo_q;
        tid_d = tid_q;
        phase_hold_d = phase_hold_q;
        latched_d = latched_q;
        cdb_class_d = cdb_class;
        if (cause_read) begin
            status_d = ssr_pkg::STATUS_RESET;
            cause_d = ssr_pkg::IRQ_CAUSE_RESET;
            step_d = ssr_pkg::STEP_RESET;
            latched_d = 1'b0;
        end
        if (cmd_end && ctl_q[ssr_pkg::CTL_PHASE_LATCH] && (!latched_q || cause_read)) begin
            latched_d = 1'b1;
            phase_hold_d = phase_s2_q;
        end
        if (cdb_valid) begin
            cdb_class_d = cls;
            if (cls.known) begin
                status_d[ssr_pkg::ST_GROUP_KNOWN] = 1'b1;
            end
        end
        // Events win over a clearing read in the same cycle
        cause_d[ssr_pkg::IC_BUS_RESET] = cause_d[ssr_pkg::IC_BUS_RESET] | ev.bus_reset_seen;
        cause_d[ssr_pkg::IC_BAD_OPCODE] = cause_d[ssr_pkg::IC_BAD_OPCODE] | ev.bad_opcode;
        cause_d[ssr_pkg::IC_LINK_DROPPED] = cause_d[ssr_pkg::IC_LINK_DROPPED] | ev.dropped
            | (timing_q && sel_timeout_d);
        cause_d[ssr_pkg::IC_SERVICE_REQ] = cause_d[ssr_pkg::IC_SERVICE_REQ] | ev.service_req;
        cause_d[ssr_pkg::IC_DONE_OK] = cause_d[ssr_pkg::IC_DONE_OK] | ev.done_ok;
        cause_d[ssr_pkg::IC_RECALLED] = cause_d[ssr_pkg::IC_RECALLED] | ev.recalled;
        cause_d[ssr_pkg::IC_CHOSEN_ATN] = cause_d[ssr_pkg::IC_CHOSEN_ATN] | ev.chosen_atn;
        cause_d[ssr_pkg::IC_CHOSEN] = cause_d[ssr_pkg::IC_CHOSEN] | ev.chosen;
        if (step_valid) begin
            step_d = step_code;
        end
        if (wr) begin
            case (paddr)
                ssr_pkg::ADDR_TARGET_ID: tid_d = pwdata[2:0];
                ssr_pkg::ADDR_SEL_TIMEOUT: tmo_d = pwdata[7:0];
                ssr_pkg::ADDR_CONTROL: ctl_d = pwdata[3:0];
                default: ;
            endcase
        end
        if (soft_reset) begin
            status_d = ssr_pkg::STATUS_RESET;
            cause_d = ssr_pkg::IRQ_CAUSE_RESET;
            step_d = ssr_pkg::STEP_RESET;
            latched_d = 1'b0;
        end
    end

    // Read data decoded in setup so it stands beside pready
    always_comb begin
        prdata_d = 32'h0000_0000;
        pslverr_d = 1'b0;
        if (psel && !penable && !pwrite) begin
            case (paddr)
                ssr_pkg::ADDR_STATUS: begin
                    prdata_d[7:0] = status_q;
                    prdata_d[2:0] = latched_q ? phase_hold_q : phase_s2_q;
                end
                ssr_pkg::ADDR_IRQ_CAUSE: prdata_d[7:0] = cause_q;
                ssr_pkg::ADDR_STEP: begin
                    prdata_d[2:0] = step_q;
                    prdata_d[ssr_pkg::STEP_SYNC_OFFSET] = !sync_offset_full;
                end
                ssr_pkg::ADDR_CONTROL: prdata_d[3:0] = ctl_q;
                default: pslverr_d = 1'b1;
            endcase
        end else if (psel && !penable && pwrite) begin
            case (paddr)
                ssr_pkg::ADDR_TARGET_ID, ssr_pkg::ADDR_SEL_TIMEOUT, ssr_pkg::ADDR_CONTROL: pslverr_d = 1'b0;
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    // Selection timeout prescaler and wrap counter
    always_comb begin
        timing_d = timing_q;
        pre_d = pre_q;
        wraps_d = wraps_q;
        sel_timeout_d = 1'b0;
        if (sel_start) begin
            timing_d = 1'b1;
            pre_d = 16'h0000;
            wraps_d = 8'h00;
        end else if (timing_q) begin
            if (sel_done || soft_reset) begin
                timing_d = 1'b0;
            end else if (pre_q == pre_limit) begin
                pre_d = 16'h0000;
                wraps_d = wraps_q + 8'h01;
                if (wraps_q + 8'h01 == tmo_q) begin
                    sel_timeout_d = 1'b1;
                    timing_d = 1'b0;
                end
            end else begin
                pre_d = pre_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_q <= ssr_pkg::STATUS_RESET;
            cause_q <= ssr_pkg::IRQ_CAUSE_RESET;
            step_q <= ssr_pkg::STEP_RESET;
            ctl_q <= ssr_pkg::CONTROL_RESET;
            tmo_q <= ssr_pkg::TIMEOUT_RESET;
            phase_hold_q <= 3'h0;
            latched_q <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            timing_q <= 1'b0;
            pre_q <= 16'h0000;
            wraps_q <= 8'h00;
            sel_timeout <= 1'b0;
            cdb_class <= '0;
        end else begin
            status_q <= status_d;
            cause_q <= cause_d;
            step_q <= step_d;
            ctl_q <= ctl_d;
            tmo_q <= tmo_d;
            phase_hold_q <= phase_hold_d;
            latched_q <= latched_d;
            prdata <= prdata_d;
            pready <= psel && !penable;
            pslverr <= pslverr_d;
            timing_q <= timing_d;
            pre_q <= pre_d;
            wraps_q <= wraps_d;
            sel_timeout <= sel_timeout_d;
            cdb_class <= cdb_class_d;
        end
    end

    // Target ID keeps its value through every reset
    always_ff @(posedge pclk) begin
        tid_q <= tid_d;
    end
    assign target_id = tid_q;
endmodule
`default_nettype wire

/* bench/ssr_bus_model.sv */
// Model of the far bus: the target's phase lines and the reset line.
// Assumes the bench asks for a phase or a bus reset on pclk.
`timescale 1ns/100ps
`default_nettype none
module ssr_bus_model (
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic [2:0] phase_req,
    input wire logic reset_req,
    // Bus pins
    output var logic [2:0] bus_phase_pin = 3'h0,
    output var logic bus_reset_pin = 1'b0
);
    // Target changes phase lines on pclk, the same clock as the registers
    always @(posedge pclk) begin
        bus_phase_pin <= phase_req;
        bus_reset_pin <= reset_req;
    end
endmodule
`default_nettype wire

/* bench/ssr_regs_properties.sv */
// Checker for the register group, bound to ssr_regs.
// Assumes one clock, pclk, and reset presetn.
`timescale 1ns/100ps
`default_nettype none
module ssr_regs_properties #(
    parameter int UNIT_CYCLES = 8192
) (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Sequencer side
    input wire logic cdb_valid,
    input wire logic [2:0] cdb_group,
    input wire logic sel_start,
    input wire logic [2:0] target_id,
    input wire logic sel_timeout,
    input wire ssr_pkg::ssr_cdb_class_type cdb_class
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_tid;
    logic written_q = 1'b0;
    assign wr_tid = psel && penable && pready && pwrite && paddr == ssr_pkg::ADDR_TARGET_ID;
    // Target ID is never reset, so neither is this
    always_ff @(posedge pclk) begin
        written_q <= written_q || wr_tid;
    end
    // Extended-groups enable as last written over the bus
    logic ext_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_q <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == ssr_pkg::ADDR_CONTROL) begin
            ext_q <= pwdata[ssr_pkg::CTL_EXT_GROUPS];
        end
    end
    AST_PREADY_SETUP: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_PREADY_ONCE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    AST_GROUP_KNOWN: assert property (cdb_valid && (cdb_group < 3'h2 || cdb_group == 3'h5)
        |=> cdb_class.known && !cdb_class.reserved) else $error("standard group not known");
    AST_GROUP_TWO: assert property (cdb_valid && cdb_group == ssr_pkg::GROUP_TWO |=>
        cdb_class.known == $past(ext_q) && (cdb_class.known ? cdb_class.length == ssr_pkg::LEN_TEN :
        cdb_class.reserved && cdb_class.length == ssr_pkg::LEN_SIX))
        else $error("group two class wrong");
    AST_GROUP_RESERVED: assert property (cdb_valid && (cdb_group == ssr_pkg::GROUP_THREE ||
        cdb_group == ssr_pkg::GROUP_FOUR) |=> cdb_class.reserved && !cdb_class.known &&
        cdb_class.length == ssr_pkg::LEN_SIX) else $error("reserved group class wrong");
    AST_GROUP_VENDOR: assert property (cdb_valid && cdb_group >= ssr_pkg::GROUP_SIX |=>
        cdb_class.vendor && !cdb_class.known && cdb_class.length ==
        ($past(cdb_group) == ssr_pkg::GROUP_SIX ? ssr_pkg::LEN_SIX : ssr_pkg::LEN_TEN))
        else $error("vendor group class wrong");
    AST_TID_WRITE: assert property (wr_tid |=> target_id == $past(pwdata[2:0])) else $error("target id not written");
    AST_TID_HOLD: assert property (written_q && !wr_tid |=> $stable(target_id)) else $error("target id moved");
    AST_SEL_FIRST_UNIT: assert property (sel_start |=> !sel_timeout [*3]) else $error("timeout too early");
    COV_GROUP_TWO: cover property (cdb_valid && cdb_group == ssr_pkg::GROUP_TWO);
    COV_TIMEOUT: cover property (sel_timeout);
    COV_TID: cover property (wr_tid);
endmodule
bind ssr_regs ssr_regs_properties #(.UNIT_CYCLES(UNIT_CYCLES)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .cdb_valid(cdb_valid), .cdb_group(cdb_group), .sel_start(sel_start), .target_id(target_id),
    .sel_timeout(sel_timeout), .cdb_class(cdb_class));
`default_nettype wire

/* bench/tb_ssr_regs.sv */
// Bench for the register group: APB tasks and sequences of calls.
// Assumes a 40 ns pclk and a four-cycle prescale unit.
`timescale 1ns/100ps
`default_nettype none
module tb_ssr_regs;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic soft_reset = 0, cdb_valid = 0, cmd_end = 0, step_valid = 0, sync_full = 0;
    logic sel_start = 0, rst_req = 0, sel_timeout, rst_pin;
    logic [2:0] grp = 3'h0, step = 3'h0, phase_req = 3'h0, phase_pin, tid;
    logic k, v, r;
    logic [3:0] len;
    ssr_pkg::ssr_event_type ev = '0;
    ssr_pkg::ssr_cdb_class_type cls;
    int num_errors = 0, compares = 0, n;
    always #20 pclk = ~pclk;
    ssr_bus_model u_bus (.pclk(pclk), .phase_req(phase_req), .reset_req(rst_req),
        .bus_phase_pin(phase_pin), .bus_reset_pin(rst_pin));
    ssr_regs #(.UNIT_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .soft_reset(soft_reset), .clock_ratio(3'h1), .cdb_valid(cdb_valid), .cdb_group(grp), .cmd_end(cmd_end),
        .step_valid(step_valid), .step_code(step), .sync_offset_full(sync_full), .sel_start(sel_start),
        .sel_done(1'b0), .events(ev), .bus_phase_pin(phase_pin), .bus_reset_pin(rst_pin), .target_id(tid),
        .sel_timeout(sel_timeout), .cdb_class(cls));
    task automatic complete_run;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 32'h0);
        check(rd, exp);
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge pclk);
    endtask
    initial begin
        tick(10);
        presetn <= 1;
        rdck(ssr_pkg::ADDR_STATUS, 0);
        rdck(ssr_pkg::ADDR_STEP, 32'h08);
        apb(0, 8'h3c, 0);
        check(32'(err), 1);
        for (int e = 0; e < 2; e++) begin
            apb(1, ssr_pkg::ADDR_CONTROL, 32'(e));
            for (int g = 0; g < 8; g++) begin
                k = g < 2 || g == 5 || (g == 2 && e == 1);
                v = g >= 6;
                r = g == 3 || g == 4 || (g == 2 && e == 0);
                len = (g == 5) ? 4'hc : (g == 7 || (g == 2 && e == 1)) ? 4'ha : 4'h6;
                @(posedge pclk);
                cdb_valid <= 1;
                grp <= 3'(g);
                @(posedge pclk);
                cdb_valid <= 0;
                @(negedge pclk);
                check({cls.known, cls.vendor, cls.reserved, g < 2 ? 4'h0 : cls.length}, {k, v, r, g < 2 ? 4'h0 : len});
                if (g == 5) rdck(ssr_pkg::ADDR_STATUS, 32'h08);
            end
            rdck(ssr_pkg::ADDR_IRQ_CAUSE, 0);
            rdck(ssr_pkg::ADDR_STATUS, 0);
        end
        apb(1, ssr_pkg::ADDR_CONTROL, 32'h0);
        for (int p = 7; p >= 0; p--) begin
            phase_req <= 3'(p);
            tick(4);
            rdck(ssr_pkg::ADDR_STATUS, 32'(p));
        end
        apb(1, ssr_pkg::ADDR_CONTROL, 32'h2);
        phase_req <= 3'h3;
        tick(4);
        cmd_end <= 1;
        tick(1);
        cmd_end <= 0;
        phase_req <= 3'h6;
        tick(4);
        rdck(ssr_pkg::ADDR_STATUS, 32'h3);
        rdck(ssr_pkg::ADDR_IRQ_CAUSE, 0);
        rdck(ssr_pkg::ADDR_STATUS, 32'h6);
        phase_req <= 3'h0;
        for (int i = 0; i < 7; i++) begin
            @(posedge pclk);
            ev <= ssr_pkg::ssr_event_type'(8'(1 << i));
            tick(1);
            ev <= '0;
            rdck(ssr_pkg::ADDR_IRQ_CAUSE, i < 2 ? 32'(2 >> i) : 32'(1 << i));
            rdck(ssr_pkg::ADDR_IRQ_CAUSE, 0);
        end
        for (int m = 0; m < 2; m++) begin
            apb(1, ssr_pkg::ADDR_CONTROL, 32'(m * 4));
            rst_req <= 1;
            tick(4);
            rst_req <= 0;
            tick(4);
            rdck(ssr_pkg::ADDR_IRQ_CAUSE, 32'(m * 128));
        end
        sync_full <= 1;
        step <= 3'h4;
        step_valid <= 1;
        tick(1);
        step_valid <= 0;
        rdck(ssr_pkg::ADDR_STEP, 32'h4);
        sync_full <= 0;
        rdck(ssr_pkg::ADDR_STEP, 32'hc);
        rdck(ssr_pkg::ADDR_IRQ_CAUSE, 0);
        rdck(ssr_pkg::ADDR_STEP, 32'h8);
        apb(1, ssr_pkg::ADDR_TARGET_ID, 32'hfd);
        @(negedge pclk);
        check(32'(tid), 5);
        // Soft reset first, then hard reset, each over a set status and cause
        for (int s = 0; s < 2; s++) begin
            @(posedge pclk);
            cdb_valid <= 1;
            grp <= 3'h0;
            ev <= ssr_pkg::ssr_event_type'(8'h08);
            @(posedge pclk);
            cdb_valid <= 0;
            ev <= '0;
            if (s == 0) soft_reset <= 1;
            else presetn <= 0;
            tick(2);
            soft_reset <= 0;
            presetn <= 1;
            rdck(ssr_pkg::ADDR_STATUS, 0);
            rdck(ssr_pkg::ADDR_IRQ_CAUSE, 0);
        end
        check(32'(tid), 5);
        apb(1, ssr_pkg::ADDR_SEL_TIMEOUT, 32'h3);
        sel_start <= 1;
        tick(1);
        sel_start <= 0;
        n = 0;
        while (sel_timeout !== 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        check(32'(n >= 10 && n <= 14), 1);
        rdck(ssr_pkg::ADDR_IRQ_CAUSE, 32'h20);
        complete_run();
    end
    initial begin
        tick(20000);
        num_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
